// >>> pkg/dce_map.vh
// Offsets, fields, codes and timing counts of the display command executor
`ifndef DCE_MAP_VH
`define DCE_MAP_VH

`define DCE_OFF_CMD        8'h00
`define DCE_OFF_DATA1      8'h04
`define DCE_OFF_R2         8'h08
`define DCE_OFF_R3         8'h0c
`define DCE_OFF_AUX_HI     8'h10
`define DCE_OFF_AUX_LO     8'h14
`define DCE_OFF_R6         8'h18
`define DCE_OFF_R7         8'h1c
`define DCE_EXEC_BIT       8
`define DCE_RESET_BYTE     8'h00

`define DCE_CLK_NS         100
`define DCE_UNIT_CLKS      12
`define DCE_HALF_CLKS      (`DCE_UNIT_CLKS / 2)
`define DCE_X_LAST         6'h27
`define DCE_PAGE_CODES     1024

`define DCE_CMD_MASK_SET   8'h99
`define DCE_CMD_MASK_CLR   8'h95

`define DCE_SEL_MAIN       2'h0
`define DCE_SEL_AUX        2'h1
`define DCE_SEL_W          2'h2

// Execution times in half units (twice the unit figure)
`define DCE_HU_IDLE        9'd2
`define DCE_HU_TWO         9'd4
`define DCE_HU_W24_W       9'd8
`define DCE_HU_W24_R       9'd15
`define DCE_HU_W16_W       9'd11
`define DCE_HU_W16_R       9'd15
`define DCE_HU_W8_W        9'd18
`define DCE_HU_W8_R        9'd19
`define DCE_HU_W12_W       9'd25
`define DCE_HU_W12_R       9'd23
`define DCE_HU_EXPD_W      9'd8
`define DCE_HU_EXPD_R      9'd15
`define DCE_HU_VAR_W       9'd12
`define DCE_HU_VAR_R       9'd7
`define DCE_HU_VAR_JW      9'd2
`define DCE_HU_VAR_JR      9'd12
`define DCE_HU_BYTE_W      9'd8
`define DCE_HU_BYTE_R      9'd9
`define DCE_HU_EXPAND      9'd12
`define DCE_HU_COMPRESS    9'd20
`define DCE_HU_MOVE_BYTE   9'd8
`define DCE_HU_MOVE_START  9'd4

`endif

// >>> rtl/dce_sync2.v
// Two-flop synchroniser for asynchronous pin levels
`default_nettype none
`include "dce_map.vh"

module dce_sync2 #(
	parameter WIDTH = 1
) (
	input  wire             pclk,
	input  wire             presetn,
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg meta_reg;
			reg sync_reg;
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta_reg <= 1'b0;
					sync_reg <= 1'b0;
				end else begin
					meta_reg <= async_in[i];
					sync_reg <= meta_reg;
				end
			end
			assign sync_out[i] = sync_reg;
		end
	endgenerate
endmodule
`default_nettype wire

// >>> rtl/dce_unit_timer.v
// Half-unit tick generator, frozen while execution is suspended
`default_nettype none
`include "dce_map.vh"

module dce_unit_timer (
	input  wire pclk,
	input  wire presetn,
	input  wire clear,
	input  wire run,
	output reg  half_tick
);
	localparam [31:0] HALF_LAST_W = `DCE_HALF_CLKS - 1;
	localparam [3:0]  HALF_LAST   = HALF_LAST_W[3:0];
	reg [3:0] div_reg;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg   <= 4'h0;
			half_tick <= 1'b0;
		end else if (clear) begin
			div_reg   <= 4'h0;
			half_tick <= 1'b0;
		end else if (run) begin
			half_tick <= (div_reg == HALF_LAST);
			div_reg   <= (div_reg == HALF_LAST) ? 4'h0 : div_reg + 4'h1;
		end else begin
			half_tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/dce_executor.v
// Command executor of the display processor with APB register access
`default_nettype none
`include "dce_map.vh"

module dce_executor #(
	parameter PAGE_CODES = `DCE_PAGE_CODES
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        vsync_in,
	input  wire        mem_grant,
	input  wire [7:0]  mem_rdata,
	output reg         mem_en,
	output reg         mem_we,
	output reg  [13:0] mem_addr,
	output reg  [7:0]  mem_wdata
);
	localparam [6:0] ST_IDLE = 7'h01;
	localparam [6:0] ST_DEC  = 7'h02;
	localparam [6:0] ST_RD   = 7'h04;
	localparam [6:0] ST_RW   = 7'h08;
	localparam [6:0] ST_CAP  = 7'h10;
	localparam [6:0] ST_WR   = 7'h20;
	localparam [6:0] ST_WAIT = 7'h40;
	localparam [2:0] MD_ONE  = 3'h0;
	localparam [2:0] MD_ROWINC = 3'h1;
	localparam [2:0] MD_ROW  = 3'h2;
	localparam [2:0] MD_PAGE = 3'h3;
	localparam [2:0] MD_MOVE = 3'h4;
	localparam [31:0] PAGE_LAST_W = PAGE_CODES - 1;
	localparam [10:0] PAGE_LAST   = PAGE_LAST_W[10:0];

	reg  [6:0]  state_reg;
	reg  [7:0]  cmd_reg;
	reg  [7:0]  data_one_reg;
	reg  [7:0]  data_two_reg;
	reg  [7:0]  data_three_reg;
	reg  [7:0]  aux_hi_reg;
	reg  [7:0]  aux_lo_reg;
	reg  [7:0]  main_y_reg;
	reg  [7:0]  main_x_reg;
	reg         busy_reg;
	reg         alarm_reg;
	reg         main_last_reg;
	reg         aux_last_reg;
	reg         mask_reg;
	reg         long_j_reg;
	reg         first_reg;
	reg  [1:0]  k_reg;
	reg  [8:0]  hcnt_reg;
	reg  [10:0] count_reg;
	wire        vsync_s;
	wire        half_tick;
	reg  [1:0]  d_nb;
	reg         d_rd;
	reg         d_wr;
	reg  [1:0]  d_src;
	reg  [1:0]  d_dst;
	reg  [2:0]  d_mode;
	reg  [8:0]  d_hu;
	reg         d_inc;
	reg         d_r3;
	reg  [13:0] src_addr;
	reg  [13:0] dst_addr;
	reg  [7:0]  fixed_byte;

	wire        mapped  = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
	wire [2:0]  idx     = paddr[4:2];
	wire        acc     = psel & penable & pready;
	wire        wr_acc  = acc & pwrite & mapped;
	wire        launch  = wr_acc && (idx == 3'h0) && pwdata[`DCE_EXEC_BIT];
	wire        copy    = d_rd & d_wr;
	wire        mx39    = (main_x_reg[5:0] == `DCE_X_LAST);
	wire        ax39    = (aux_lo_reg[5:0] == `DCE_X_LAST);
	wire [7:0]  mx_inc  = {main_x_reg[7:6], mx39 ? 6'h00 : main_x_reg[5:0] + 6'h01};
	wire [7:0]  ax_inc  = {aux_lo_reg[7:6], ax39 ? 6'h00 : aux_lo_reg[5:0] + 6'h01};
	wire [7:0]  my_inc  = {main_y_reg[7:5], main_y_reg[4:0] + 5'h01};
	wire        aux_ptr = (d_src == `DCE_SEL_AUX);
	wire        is_var  = (cmd_reg[7:4] == 4'h2);
	wire        is_byte = (cmd_reg[7:4] == 4'h3);
	wire        stop_end  = (cmd_reg[1:0] == 2'b01);
	wire [8:0]  target  = d_hu + ((first_reg && d_mode == MD_MOVE) ? `DCE_HU_MOVE_START : 9'd0);
	wire        step_done = (hcnt_reg >= target);
	wire        vs_bit  = vsync_s & ~mask_reg;
	wire [7:0]  status  = {busy_reg, alarm_reg, main_last_reg, aux_last_reg, data_one_reg[7],
		vs_bit, 2'b00};
	wire [7:0]  k_next  = {6'h00, k_reg} + 8'h01;

	dce_sync2 #(
		.WIDTH(1)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (vsync_in),
		.sync_out (vsync_s)
	);

	// Suspension applies to every command: the timer runs only while busy_reg and mem_grant are both high
	dce_unit_timer u_timer (
		.pclk      (pclk),
		.presetn   (presetn),
		.clear     (state_reg == ST_DEC),
		.run       (busy_reg & mem_grant),
		.half_tick (half_tick)
	);

	always @* begin
		d_nb   = 2'd0;
		d_rd   = 1'b0;
		d_wr   = 1'b0;
		d_src  = `DCE_SEL_MAIN;
		d_dst  = `DCE_SEL_MAIN;
		d_mode = MD_ONE;
		d_hu   = `DCE_HU_IDLE;
		d_inc  = cmd_reg[0];
		d_r3   = 1'b0;
		case (cmd_reg[7:4])
			4'h0: begin
				d_nb   = cmd_reg[1] ? 2'd2 : 2'd3;
				d_rd   = cmd_reg[3] & ~cmd_reg[2];
				d_wr   = ~d_rd;
				d_mode = cmd_reg[2] ? MD_PAGE : MD_ONE;
				if (cmd_reg[1])
					d_hu = d_rd ? `DCE_HU_W16_R : `DCE_HU_W16_W;
				else
					d_hu = d_rd ? `DCE_HU_W24_R : `DCE_HU_W24_W;
			end
			4'h1: begin
				d_nb  = 2'd2;
				d_rd  = cmd_reg[3];
				d_wr  = ~cmd_reg[3];
				d_src = `DCE_SEL_W;
				d_dst = `DCE_SEL_W;
				d_r3  = 1'b1;
				d_hu  = d_rd ? `DCE_HU_EXPD_R : `DCE_HU_EXPD_W;
			end
			4'h2: begin
				d_nb = 2'd3;
				d_rd = cmd_reg[3];
				d_wr = ~cmd_reg[3];
				d_hu = d_rd ? `DCE_HU_VAR_R + (long_j_reg ? `DCE_HU_VAR_JR : 9'd0)
					: `DCE_HU_VAR_W + (long_j_reg ? `DCE_HU_VAR_JW : 9'd0);
			end
			4'h3: begin
				d_nb  = 2'd1;
				d_rd  = cmd_reg[3];
				d_wr  = ~cmd_reg[3];
				d_src = cmd_reg[2] ? `DCE_SEL_AUX : `DCE_SEL_MAIN;
				d_dst = d_src;
				d_hu  = d_rd ? `DCE_HU_BYTE_R : `DCE_HU_BYTE_W;
			end
			4'h4: begin
				d_nb = 2'd1;
				d_rd = cmd_reg[3];
				d_wr = ~cmd_reg[3];
				d_hu = d_rd ? `DCE_HU_W8_R : `DCE_HU_W8_W;
			end
			4'h5: begin
				d_nb = 2'd2;
				d_rd = cmd_reg[3];
				d_wr = ~cmd_reg[3];
				d_r3 = 1'b1;
				d_hu = d_rd ? `DCE_HU_W12_R : `DCE_HU_W12_W;
			end
			4'h6, 4'h7: begin
				d_nb   = 2'd1;
				d_rd   = 1'b1;
				d_wr   = 1'b1;
				d_src  = cmd_reg[4] ? `DCE_SEL_W : `DCE_SEL_MAIN;
				d_dst  = cmd_reg[4] ? `DCE_SEL_MAIN : `DCE_SEL_W;
				d_mode = MD_ROW;
				d_hu   = cmd_reg[4] ? `DCE_HU_COMPRESS : `DCE_HU_EXPAND;
			end
			4'h8: d_hu = `DCE_HU_TWO;
			4'hb: begin
				d_mode = MD_ROWINC;
				d_hu   = `DCE_HU_TWO;
			end
			4'hd, 4'he, 4'hf: begin
				d_nb   = cmd_reg[5:4] - 2'd0;
				d_rd   = 1'b1;
				d_wr   = 1'b1;
				d_src  = (cmd_reg[3:2] == 2'b10) ? `DCE_SEL_AUX : `DCE_SEL_MAIN;
				d_dst  = (cmd_reg[3:2] == 2'b10) ? `DCE_SEL_MAIN : `DCE_SEL_AUX;
				d_mode = MD_MOVE;
				d_hu   = `DCE_HU_MOVE_BYTE * {7'h00, cmd_reg[5:4]} - 9'd0;
			end
			default: d_hu = `DCE_HU_IDLE;
		endcase
		if (cmd_reg[7:4] == 4'hd)
			d_nb = 2'd1;
		else if (cmd_reg[7:4] == 4'he)
			d_nb = 2'd2;
		else if (cmd_reg[7:4] == 4'hf)
			d_nb = 2'd3;
	end

	always @* begin
		src_addr = {main_y_reg + {6'h00, k_reg}, main_x_reg[5:0]};
		dst_addr = src_addr;
		if (d_src == `DCE_SEL_AUX)
			src_addr = {aux_hi_reg + {6'h00, k_reg}, aux_lo_reg[5:0]};
		else if (d_src == `DCE_SEL_W)
			src_addr = {aux_hi_reg[7:5], main_y_reg[4:0] + {3'h0, k_reg}, main_x_reg[5:0]};
		if (d_dst == `DCE_SEL_AUX)
			dst_addr = {aux_hi_reg + {6'h00, k_reg}, aux_lo_reg[5:0]};
		else if (d_dst == `DCE_SEL_W)
			dst_addr = {aux_hi_reg[7:5], main_y_reg[4:0] + {3'h0, k_reg}, main_x_reg[5:0]};
		if (k_reg == 2'd0)
			fixed_byte = data_one_reg;
		else if (k_reg == 2'd1 && !d_r3)
			fixed_byte = data_two_reg;
		else
			fixed_byte = data_three_reg;
	end

	// APB: one wait state so that read data and the error come from flops
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped;
			if (psel & penable & ~pready & mapped & ~pwrite) begin
				if (idx == 3'h0)
					prdata <= {24'h000000, status};
				else if (idx == 3'h1)
					prdata <= {24'h000000, data_one_reg};
				else if (idx == 3'h2)
					prdata <= {24'h000000, data_two_reg};
				else if (idx == 3'h3)
					prdata <= {24'h000000, data_three_reg};
				else if (idx == 3'h4)
					prdata <= {24'h000000, aux_hi_reg};
				else if (idx == 3'h5)
					prdata <= {24'h000000, aux_lo_reg};
				else if (idx == 3'h6)
					prdata <= {24'h000000, main_y_reg};
				else
					prdata <= {24'h000000, main_x_reg};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			cmd_reg <= `DCE_RESET_BYTE;
			data_one_reg <= `DCE_RESET_BYTE;
			data_two_reg <= `DCE_RESET_BYTE;
			data_three_reg <= `DCE_RESET_BYTE;
			aux_hi_reg <= `DCE_RESET_BYTE;
			aux_lo_reg <= `DCE_RESET_BYTE;
			main_y_reg <= `DCE_RESET_BYTE;
			main_x_reg <= `DCE_RESET_BYTE;
			busy_reg <= 1'b0;
			alarm_reg <= 1'b0;
			main_last_reg <= 1'b0;
			aux_last_reg <= 1'b0;
			mask_reg <= 1'b0;
			long_j_reg <= 1'b0;
			first_reg <= 1'b0;
			k_reg <= 2'd0;
			hcnt_reg <= 9'd0;
			count_reg <= 11'd0;
			mem_en <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= 14'h0000;
			mem_wdata <= 8'h00;
		end else if (launch) begin
			cmd_reg <= pwdata[7:0];
			busy_reg <= 1'b1;
			alarm_reg <= 1'b0;
			main_last_reg <= 1'b0;
			aux_last_reg <= 1'b0;
			mem_en <= 1'b0;
			mem_we <= 1'b0;
			state_reg <= ST_DEC;
		end else begin
			mem_en <= 1'b0;
			mem_we <= 1'b0;
			// Register writes while busy are ignored, except a launch, so the engine owns its arguments
			if (wr_acc && !busy_reg) begin
				if (idx == 3'h0)
					cmd_reg <= pwdata[7:0];
				else if (idx == 3'h1)
					data_one_reg <= pwdata[7:0];
				else if (idx == 3'h2)
					data_two_reg <= pwdata[7:0];
				else if (idx == 3'h3)
					data_three_reg <= pwdata[7:0];
				else if (idx == 3'h4)
					aux_hi_reg <= pwdata[7:0];
				else if (idx == 3'h5)
					aux_lo_reg <= pwdata[7:0];
				else if (idx == 3'h6)
					main_y_reg <= pwdata[7:0];
				else
					main_x_reg <= pwdata[7:0];
			end
			if (half_tick && hcnt_reg != 9'h1ff)
				hcnt_reg <= hcnt_reg + 9'd1;
			case (state_reg)
				ST_DEC: begin
					long_j_reg <= data_one_reg[7];
					if (cmd_reg == `DCE_CMD_MASK_SET)
						mask_reg <= 1'b1;
					else if (cmd_reg == `DCE_CMD_MASK_CLR)
						mask_reg <= 1'b0;
					first_reg <= 1'b1;
					k_reg <= 2'd0;
					hcnt_reg <= 9'd0;
					count_reg <= 11'd0;
					state_reg <= (d_nb == 2'd0) ? ST_WAIT : (d_rd ? ST_RD : ST_WR);
				end
				ST_RD: begin
					if (mem_grant) begin
						mem_en <= 1'b1;
						mem_addr <= src_addr;
						state_reg <= ST_RW;
					end
				end
				ST_RW: state_reg <= ST_CAP;
				ST_CAP: begin
					if (copy || k_reg == 2'd0)
						data_one_reg <= mem_rdata;
					else if (k_reg == 2'd1 && !d_r3)
						data_two_reg <= mem_rdata;
					else
						data_three_reg <= mem_rdata;
					if (d_wr)
						state_reg <= ST_WR;
					else if (k_next[1:0] < d_nb) begin
						k_reg <= k_next[1:0];
						state_reg <= ST_RD;
					end else
						state_reg <= ST_WAIT;
				end
				ST_WR: begin
					if (mem_grant) begin
						mem_en <= 1'b1;
						mem_we <= 1'b1;
						mem_addr <= dst_addr;
						mem_wdata <= copy ? data_one_reg : fixed_byte;
						if (k_next[1:0] < d_nb) begin
							k_reg <= k_next[1:0];
							state_reg <= d_rd ? ST_RD : ST_WR;
						end else
							state_reg <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (step_done) begin
						busy_reg <= 1'b0;
						state_reg <= ST_IDLE;
						case (d_mode)
							MD_ONE: begin
								if (aux_ptr) begin
									aux_last_reg <= aux_last_reg | ax39;
									if (d_inc) begin
										aux_lo_reg <= ax_inc;
										alarm_reg <= alarm_reg | ax39;
									end
								end else if (d_nb != 2'd0) begin
									main_last_reg <= main_last_reg | mx39;
									if (d_inc) begin
										main_x_reg <= mx_inc;
										alarm_reg <= alarm_reg | mx39;
										if (is_byte && mx39)
											main_y_reg <= my_inc;
									end
								end
								if (is_var) begin
									aux_last_reg <= aux_last_reg | ax39;
									if (d_inc)
										aux_lo_reg <= ax_inc;
								end
							end
							MD_ROWINC: main_y_reg <= my_inc;
							MD_ROW: begin
								main_x_reg <= mx_inc;
								if (data_one_reg[7] && aux_last_reg)
									alarm_reg <= 1'b1;
								else begin
									if (data_one_reg[7]) begin
										aux_lo_reg <= ax_inc;
										aux_last_reg <= ax39;
									end
									if (!mx39) begin
										busy_reg <= 1'b1;
										state_reg <= ST_RD;
									end
								end
							end
							MD_PAGE: begin
								main_x_reg <= mx_inc;
								if (mx39) begin
									main_last_reg <= 1'b1;
									main_y_reg <= my_inc;
								end
								count_reg <= count_reg + 11'd1;
								if (count_reg != PAGE_LAST) begin
									busy_reg <= 1'b1;
									state_reg <= ST_WR;
								end
							end
							default: begin
								main_x_reg <= mx_inc;
								aux_lo_reg <= ax_inc;
								if (mx39 && !stop_end)
									main_y_reg <= my_inc;
								if (!(stop_end && (mx39 || ax39))) begin
									busy_reg <= 1'b1;
									state_reg <= ST_RD;
								end
							end
						endcase
						k_reg <= 2'd0;
						hcnt_reg <= 9'd0;
						first_reg <= 1'b0;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> dv/dce_executor_asserts.sv
// Port checker for the display command executor
`default_nettype none
`include "dce_map.vh"
module dce_executor_asserts (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        mem_grant,
	input wire logic        mem_en
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       bad;
	logic       go;
	logic       rdst;
	logic       started;
	logic       mask_on;
	logic [5:0] age;
	assign bad = (paddr[7:5] != 3'h0) || (paddr[1:0] != 2'h0);
	assign go = pready && pwrite && !bad && paddr == `DCE_OFF_CMD && pwdata[8];
	assign rdst = pready && !pwrite && !bad && paddr == `DCE_OFF_CMD;
	// Mask is trusted only once the mask command has surely finished
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			started <= 1'b0;
			mask_on <= 1'b0;
			age <= 6'h00;
		end else if (go) begin
			started <= 1'b1;
			mask_on <= pwdata[7:0] == `DCE_CMD_MASK_SET;
			age <= 6'h00;
		end else if (age != 6'h3f) begin
			age <= age + 6'h01;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	rdy_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
	rdy_wait_a: assert property (psel && $rose(penable) |=> pready) else $error("pready late");
	rdy_phase_a: assert property (pready |-> psel && penable) else $error("pready outside access");
	rd_idle_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
		else $error("prdata not zero");
	rd_upper_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("prdata upper set");
	err_addr_a: assert property (pready |-> pslverr == bad) else $error("pslverr wrong");
	mask_read_a: assert property (rdst && mask_on && age >= 6'd40 |-> !prdata[2])
		else $error("masked vsync bit set");
	no_launch_a: assert property (!started |-> !mem_en)
		else $error("memory access without launch");
	stall_hold_a: assert property (!mem_grant [*2] |=> !mem_en)
		else $error("memory access while withheld");
endmodule
bind dce_executor dce_executor_asserts u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.mem_grant(mem_grant), .mem_en(mem_en)
);
`default_nettype wire

// >>> dv/dce_mem_model.sv
// Behavioural display memory on the executor's far side
`default_nettype none
module dce_mem_model (
	input  wire logic        pclk,
	input  wire logic        stall,
	input  wire logic        mem_en,
	input  wire logic        mem_we,
	input  wire logic [13:0] mem_addr,
	input  wire logic [7:0]  mem_wdata,
	output wire logic        mem_grant,
	output var  logic [7:0]  mem_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:16383];
	initial begin
		for (int i = 0; i < 16384; i++)
			mem[i] = 8'(i) ^ 8'h5a;
		mem_rdata = 8'h00;
	end
	assign mem_grant = !stall;
	// Read data stands only up to the capture edge, then flips so late use shows
	always @(posedge pclk) begin
		if (mem_en && !mem_we)
			mem_rdata <= mem[mem_addr];
		else
			mem_rdata <= ~mem_rdata;
		if (mem_en && mem_we)
			mem[mem_addr] <= mem_wdata;
	end
endmodule
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for the display command executor
`default_nettype none
`include "dce_map.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {
		logic [8:0] cmd;
		logic [7:0] x7;
		logic [7:0] x5;
		int         nwr;
		logic [7:0] st;
		int         lo;
		int         hi;
	} dce_row_t;
	logic        pclk, presetn, psel, penable, pwrite, vsync_in, stall, mv;
	logic [7:0]  paddr, mem_wdata, mem_rdata, lastr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, err, mem_grant, mem_en, mem_we;
	logic [13:0] mem_addr;
	int          n_errors, samples_checked, nw, bad_cp, t0, dt, cyc;
	// Moves stop after two steps (2, 4 or 6 words): aux X reaches 39 first
	dce_row_t rows [10] = '{
		'{9'h191, 8'h00, 8'h00, 0, 8'h00, 8, 30},
		'{9'h1c0, 8'h00, 8'h00, 0, 8'h00, 0, 30},
		'{9'h1d5, 8'h25, 8'h26, 2, 8'h00, 110, 140},
		'{9'h1e5, 8'h25, 8'h26, 4, 8'h00, 205, 240},
		'{9'h1f5, 8'h25, 8'h26, 6, 8'h00, 300, 340},
		'{9'h105, 8'h00, 8'h00, 12, 8'hff, 180, 230},
		'{9'h107, 8'h00, 8'h00, 8, 8'hff, 250, 300},
		'{9'h121, 8'h00, 8'h27, 3, 8'h10, 84, 110},
		'{9'h160, 8'h27, 8'h00, 1, 8'hff, 70, 90},
		'{9'h131, 8'h27, 8'h00, 1, 8'h60, 40, 70}
	};
	dce_executor #(.PAGE_CODES(4)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.vsync_in(vsync_in), .mem_grant(mem_grant), .mem_rdata(mem_rdata), .mem_en(mem_en),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata)
	);
	dce_mem_model M (
		.pclk(pclk), .stall(stall), .mem_en(mem_en), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_grant(mem_grant), .mem_rdata(mem_rdata)
	);
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (mem_en === 1'b1 && mem_we !== 1'b1)
			lastr = M.mem[mem_addr];
		if (mem_en === 1'b1 && mem_we === 1'b1) begin
			nw = nw + 1;
			if (mv && mem_wdata !== lastr)
				bad_cp = bad_cp + 1;
		end
	end
	task automatic finish_test();
		if (n_errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
		samples_checked++;
		if (g < lo || g > hi) begin
			n_errors++;
			$display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask
	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic setp(input logic [7:0] x7, input logic [7:0] x5);
		apb(1'b1, `DCE_OFF_DATA1, 32'ha5);
		apb(1'b1, `DCE_OFF_AUX_HI, 32'h00);
		apb(1'b1, `DCE_OFF_AUX_LO, {24'h0, x5});
		apb(1'b1, `DCE_OFF_R6, 32'h02);
		apb(1'b1, `DCE_OFF_R7, {24'h0, x7});
	endtask
	task automatic launch(input logic [8:0] c);
		apb(1'b1, `DCE_OFF_CMD, {23'h0, c});
		t0 = cyc;
		nw = 0;
	endtask
	// Polling costs a few cycles, so times are checked as windows
	task automatic wait_idle();
		int k;
		k = 0;
		apb(1'b0, `DCE_OFF_CMD, 32'h0);
		chk("busy", 32'h80, rd & 32'h80);
		while (rd[7] !== 1'b0 && k < 3000) begin
			apb(1'b0, `DCE_OFF_CMD, 32'h0);
			k++;
		end
		dt = cyc - t0;
		if (k >= 3000)
			n_errors++;
	endtask
	initial begin
		{psel, penable, pwrite, stall, mv} = 5'h00;
		n_errors = 0;
		samples_checked = 0;
		nw = 0;
		bad_cp = 0;
		cyc = 0;
		vsync_in = 1'b1;
		paddr = 8'h00;
		pwdata = 32'h0;
		presetn = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `DCE_OFF_CMD, 32'h0);
		chk("reset status", 32'h0, rd & 32'hf0);
		apb(1'b0, 8'h24, 32'h0);
		chk("unmapped", 32'h1, {rd[30:0], err});
		foreach (rows[i]) begin
			setp(rows[i].x7, rows[i].x5);
			mv = rows[i].cmd == 9'h1d5;
			launch(rows[i].cmd);
			wait_idle();
			chk_rng("time", rows[i].lo, rows[i].hi, dt);
			chk("writes", rows[i].nwr, nw);
			if (rows[i].st !== 8'hff)
				chk("flags", {24'h0, rows[i].st}, rd & 32'h70);
		end
		chk("copied data", 0, bad_cp);
		apb(1'b0, `DCE_OFF_R6, 32'h0);
		chk("y after wrap", 32'h03, rd);
		apb(1'b0, `DCE_OFF_R7, 32'h0);
		chk("x after wrap", 32'h00, rd);
		setp(8'h10, 8'h00);
		apb(1'b1, `DCE_OFF_CMD, 32'h0b0);
		apb(1'b0, `DCE_OFF_CMD, 32'h0);
		chk("no launch", 32'h0, rd & 32'h80);
		launch(9'h1b0);
		wait_idle();
		chk_rng("row step time", 20, 36, dt);
		apb(1'b0, `DCE_OFF_R6, 32'h0);
		chk("y stepped", 32'h03, rd);
		apb(1'b0, `DCE_OFF_R7, 32'h0);
		chk("x kept", 32'h10, rd);
		launch({1'b1, `DCE_CMD_MASK_CLR});
		wait_idle();
		chk("vsync high", 32'h04, rd & 32'h04);
		vsync_in <= 1'b0;
		repeat (4) @(posedge pclk);
		apb(1'b0, `DCE_OFF_CMD, 32'h0);
		chk("vsync low", 32'h0, rd & 32'h04);
		launch({1'b1, `DCE_CMD_MASK_SET});
		wait_idle();
		vsync_in <= 1'b1;
		repeat (40) @(posedge pclk);
		apb(1'b0, `DCE_OFF_CMD, 32'h0);
		chk("masked", 32'h0, rd & 32'h04);
		launch({1'b1, `DCE_CMD_MASK_CLR});
		wait_idle();
		chk("unmasked", 32'h04, rd & 32'h04);
		setp(8'h25, 8'h26);
		mv = 1'b1;
		launch(9'h1d5);
		repeat (30) @(posedge pclk);
		stall <= 1'b1;
		repeat (100) @(posedge pclk);
		stall <= 1'b0;
		wait_idle();
		chk_rng("stalled time", 210, 245, dt);
		setp(8'h00, 8'h00);
		mv = 1'b0;
		launch(9'h1d6);
		repeat (1500) @(posedge pclk);
		apb(1'b0, `DCE_OFF_CMD, 32'h0);
		chk("endless busy", 32'h80, rd & 32'h80);
		chk_rng("endless words", 20, 40, nw);
		launch(9'h191);
		wait_idle();
		chk_rng("abort time", 0, 36, dt);
		finish_test();
	end
	initial begin
		#6000000;
		n_errors++;
		finish_test();
	end
endmodule
`default_nettype wire
